//--- pif_pkg.sv
// Package for the peripheral interrupt flag block: offsets, fields, types.
// Assumes a 32-bit APB register bus with word-aligned registers.
package pif_pkg;

  localparam logic [11:0] ADDR_CMP_FLAGS = 12'h000;
  localparam logic [11:0] ADDR_SER_FLAGS = 12'h004;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h008;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h00C;

  localparam int BIT_ZERO_CROSS = 6;
  localparam int BIT_CMP_TWO = 1;
  localparam int BIT_CMP_ONE = 0;
  localparam int BIT_SER_RX = 5;
  localparam int BIT_SER_TX = 4;
  localparam int BIT_BCL_TWO = 3;
  localparam int BIT_SSP_TWO = 2;
  localparam int BIT_BCL_ONE = 1;
  localparam int BIT_SSP_ONE = 0;

  localparam logic [7:0] CMP_IMPL_MASK = 8'h43;
  localparam logic [7:0] SER_SW_MASK = 8'h0F;
  localparam logic [7:0] FLAG_RESET = 8'h00;
  localparam logic [8:0] IRQ_RESET = 9'h000;

  // Event strobes from the peripherals, one cycle or level per event.
  typedef struct packed {
    logic zeroCross;
    logic cmpTwo;
    logic cmpOne;
    logic bclTwo;
    logic sspTwo;
    logic bclOne;
    logic sspOne;
  } pif_events_t;

  // Buffer state levels from the serial port.
  typedef struct packed {
    logic rxNotEmpty;
    logic txNotFull;
  } pif_buf_t;

endpackage

//--- pif_flag_bit.sv
// One hardware-set, software-cleared flag bit.
// Assumes set and clear are single-cycle terms on clk; set wins over clear.
`timescale 1ns/100ps
`default_nettype none
module pif_flag_bit (
  input wire logic clk,
  input wire logic rst,
  input wire logic setEvt,
  input wire logic swWrite,
  input wire logic swValue,
  output logic flag
);

  logic flag_q;
  logic flag_d;

  assign flag_d = setEvt ? 1'b1 : (swWrite ? swValue : flag_q);
  assign flag = flag_q;

  always_ff @(posedge clk)
  begin
    if (rst)
      flag_q <= 1'b0;
    else
      flag_q <= flag_d;
  end

endmodule
`default_nettype wire

//--- pif_flags.sv
// Peripheral interrupt flag registers with APB slave and interrupt output.
// Assumes event inputs are synchronous to clk; buffer levels too.
//
// Overview of operation
// - Zero-cross flag set by hardware on detected event, held until cleared.
// - Comparator two flag set on its interrupt, held until software clears.
// - Comparator one flag set on its interrupt, held until software clears.
// - Unimplemented bits read zero and ignore writes.
// - Flags set on events regardless of any enable bit.
// - All implemented flags reset to zero on every reset.
`timescale 1ns/100ps
`default_nettype none
module pif_flags (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire pif_pkg::pif_events_t events,
  input wire pif_pkg::pif_buf_t bufState,
  output logic irq
);

  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;
  logic [8:0] stat_q;
  logic [8:0] stat_d;
  logic [8:0] mask_q;
  logic [1:0] buf_q;
  logic [6:0] prevEvt_q;

  wire setup = psel && !penable;
  wire access = psel && penable && pready_q;
  wire wrAcc = access && pwrite;
  wire hitCmp = (paddr == pif_pkg::ADDR_CMP_FLAGS);
  wire hitSer = (paddr == pif_pkg::ADDR_SER_FLAGS);
  wire hitStat = (paddr == pif_pkg::ADDR_IRQ_STAT);
  wire hitMask = (paddr == pif_pkg::ADDR_IRQ_MASK);
  wire hitAny = hitCmp || hitSer || hitStat || hitMask;

  // Event vector in status bit order.
  wire [6:0] evtVec = {events.zeroCross, events.cmpTwo, events.cmpOne,
                       events.bclTwo, events.sspTwo, events.bclOne,
                       events.sspOne};
  // Rising edges only, so a held level sets a flag once.
  wire [6:0] evtRise = evtVec & ~prevEvt_q;

  // Flag storage: cmp bits 6,1,0 and serial bits 3..0.
  wire [6:0] flagSet;
  wire [6:0] flagWr;
  wire [6:0] flagVal;
  wire [6:0] flagQ;

  assign flagSet = evtRise;
  assign flagWr = {{3{wrAcc && hitCmp}}, {4{wrAcc && hitSer}}};
  assign flagVal = {pwdata[pif_pkg::BIT_ZERO_CROSS],
                    pwdata[pif_pkg::BIT_CMP_TWO],
                    pwdata[pif_pkg::BIT_CMP_ONE],
                    pwdata[pif_pkg::BIT_BCL_TWO],
                    pwdata[pif_pkg::BIT_SSP_TWO],
                    pwdata[pif_pkg::BIT_BCL_ONE],
                    pwdata[pif_pkg::BIT_SSP_ONE]};

  // Each flag sets on its event and holds until written zero.
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1)
    begin : gFlag
      pif_flag_bit uFlag (
        .clk(clk),
        .rst(rst),
        .setEvt(flagSet[gi]),
        .swWrite(flagWr[gi]),
        .swValue(flagVal[gi]),
        .flag(flagQ[gi])
      );
    end
  endgenerate

  // Register images; unimplemented bits are tied to zero.
  wire [7:0] cmpImage = {1'b0, flagQ[6], 4'h0, flagQ[5], flagQ[4]};
  wire [7:0] serImage = {2'b00, buf_q, flagQ[3:0]};

  wire [8:0] statEvt = {buf_q[1], buf_q[0], evtRise};
  // Only the bits returned by this read are cleared, so an event that
  // arrives between the setup capture and the access edge is kept.
  wire [8:0] statClr = (access && !pwrite && hitStat) ? prdata_q[8:0] : 9'h000;
  assign stat_d = statEvt | (stat_q & ~statClr);

  wire [31:0] rdMux =
    hitCmp ? {24'h000000, cmpImage & pif_pkg::CMP_IMPL_MASK} :
    hitSer ? {24'h000000, serImage} :
    hitStat ? {23'h000000, stat_q} :
    hitMask ? {23'h000000, mask_q} : 32'h00000000;

  always_comb
  begin
    prdata_d = prdata_q;
    if (setup && !pwrite)
      prdata_d = rdMux;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      prevEvt_q <= 7'h00;
      buf_q <= 2'b00;
    end
    else
    begin
      prevEvt_q <= evtVec;
      buf_q <= {bufState.rxNotEmpty, bufState.txNotFull};
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup && !hitAny;
      prdata_q <= prdata_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      stat_q <= pif_pkg::IRQ_RESET;
      mask_q <= pif_pkg::IRQ_RESET;
      irq_q <= 1'b0;
    end
    else
    begin
      stat_q <= stat_d;
      if (wrAcc && hitMask)
        mask_q <= pwdata[8:0];
      irq_q <= |(stat_d & mask_q);
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

endmodule
`default_nettype wire

//--- pif_flags_sva.sv
// Checker for the flag block.
// Assumes the APB master holds paddr and pwrite through the access.
`timescale 1ns/100ps
`default_nettype none
module pif_flags_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire pif_pkg::pif_events_t events,
  input wire pif_pkg::pif_buf_t bufState,
  input wire logic irq
);
  logic [2:0] seen_q;
  wire rd0 = pready && !pwrite && paddr == pif_pkg::ADDR_CMP_FLAGS;
  wire rd4 = pready && !pwrite && paddr == pif_pkg::ADDR_SER_FLAGS;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  always_ff @(posedge clk)
  begin
    if (rst)
      seen_q <= 3'h0;
    else
      seen_q <= seen_q | {events.zeroCross, events.cmpTwo, events.cmpOne};
  end
  chk_zc_quiet: assert property (rd0 && !seen_q[2] |-> !prdata[6])
    else $error("zc flag");
  chk_c2_quiet: assert property (rd0 && !seen_q[1] |-> !prdata[1])
    else $error("c2 flag");
  chk_c1_quiet: assert property (rd0 && !seen_q[0] |-> !prdata[0])
    else $error("c1 flag");
  chk_cmp_unimpl: assert property (rd0 |-> (prdata & ~32'h43) == 32'h0)
    else $error("cmp bits");
  chk_ser_unimpl: assert property (rd4 |-> prdata[31:6] == 26'h0)
    else $error("ser bits");
  chk_reset_quiet: assert property (disable iff (1'b0) rst |=> !irq && !pready)
    else $error("reset out");
  chk_buf_follow: assert property (rd4 && $stable(bufState)
    && $past(bufState, 2) == bufState |-> prdata[5:4] == bufState)
    else $error("buf flags");
endmodule
bind pif_flags pif_flags_sva chk (.*);
`default_nettype wire

//--- pif_periph.sv
// Peripheral model: event strobes and serial buffer levels.
// Assumes the bench requests pulses and levels in step with clk.
`timescale 1ns/100ps
`default_nettype none
module pif_periph (
  input wire logic clk,
  input wire logic [6:0] fire,
  input wire logic [1:0] lvl,
  output var pif_pkg::pif_events_t events,
  output var pif_pkg::pif_buf_t bufState
);
  always_ff @(posedge clk)
  begin
    events <= fire;
    bufState <= lvl;
  end
endmodule
`default_nettype wire

//--- peripheral_interrupt_flags_tb.sv
// Bench for the flag block: APB tasks, event and buffer scenarios.
// Assumes the peripheral model drives the event and buffer inputs.
`timescale 1ns/100ps
`default_nettype none
module peripheral_interrupt_flags_tb;
  logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, irq;
  logic [6:0] fire = 7'h00;
  logic [1:0] lvl = 2'h0;
  pif_pkg::pif_events_t events;
  pif_pkg::pif_buf_t bufState;
  int mismatches = 0, cmp_count = 0;
  pif_periph peer (.clk(clk), .fire(fire), .lvl(lvl), .events(events),
    .bufState(bufState));
  pif_flags uut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .events(events),
    .bufState(bufState), .irq(irq));
  initial
  begin
    forever #2 clk = ~clk;
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [11:0] a,
    input logic [31:0] d, input logic [31:0] exp);
    int n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1)
    begin
      mismatches++;
      end_sim();
    end
    err = pslverr;
    if (!w)
      chk(prdata, exp);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic pulse(input logic [6:0] f);
    fire <= f;
    @(posedge clk);
    fire <= 7'h00;
    repeat (4) @(posedge clk);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 16; i += 4) xfer(0, 12'(i), 0, 32'h0);
    xfer(1, 12'h000, 32'hBC, 0);
    xfer(0, 12'h000, 0, 32'h0);
    for (int i = 0; i < 7; i++) pulse(7'(1 << i));
    xfer(0, 12'h000, 0, 32'h43);
    xfer(0, 12'h004, 0, 32'h0F);
    xfer(0, 12'h008, 0, 32'h7F);
    xfer(1, 12'h000, 32'h0, 0);
    xfer(0, 12'h008, 0, 32'h0);
    xfer(1, 12'h00C, 32'h1FF, 0);
    pulse(7'h40);
    chk(32'(irq), 32'h1);
    xfer(0, 12'h008, 0, 32'h40);
    chk(32'(irq), 32'h0);
    xfer(0, 12'h000, 0, 32'h40);
    xfer(1, 12'h004, 32'hFF, 0);
    xfer(0, 12'h004, 0, 32'h0F);
    lvl <= 2'h3;
    repeat (3) @(posedge clk);
    xfer(0, 12'h004, 0, 32'h3F);
    xfer(1, 12'h004, 32'h0, 0);
    xfer(0, 12'h004, 0, 32'h30);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    xfer(0, 12'h000, 0, 32'h0);
    xfer(0, 12'h010, 0, 32'h0);
    chk(32'(err), 32'h1);
    end_sim();
  end
endmodule
`default_nettype wire
